// [dsw_drive_status_word.v]
// Drive status word: power state machine, flags, register port, interrupt
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "dsw_defines.vh"
module dsw_drive_status_word
#(
    parameter SPEED_W = 16
)
(
    // Clock and reset
    input  wire               clock,
    input  wire               rst_n,
    // Drive pins, asynchronous
    input  wire               faultIn,
    input  wire               alarmIn,
    input  wire               mainsPresent,
    input  wire               stopKeyIn,
    input  wire               reverseIn,
    input  wire               networkCmd,
    // Control commands, same clock, one-cycle pulses
    input  wire               cmdShutdown,
    input  wire               cmdSwitchOn,
    input  wire               cmdEnableOp,
    input  wire               cmdDisableOp,
    input  wire               cmdDisableVoltage,
    input  wire               cmdQuickStop,
    input  wire               cmdFaultReset,
    // Speed values, same clock
    input  wire [SPEED_W-1:0] speedRef,
    input  wire [SPEED_W-1:0] speedActual,
    // Register port
    input  wire [3:0]         regAddr,
    input  wire [15:0]        regWrData,
    input  wire               regWr,
    input  wire               regRd,
    output reg  [15:0]        regRdData,
    // Status out
    output reg  [15:0]        driveStateFlags,
    output reg                irq
);

////////////////////////////////////////////////////////////////////////////////
// Power states
localparam [2:0] ST_NOT_READY   = 3'h0;
localparam [2:0] ST_SO_DISABLED = 3'h1;
localparam [2:0] ST_READY       = 3'h2;
localparam [2:0] ST_SWITCHED_ON = 3'h3;
localparam [2:0] ST_OP_ENABLED  = 3'h4;
localparam [2:0] ST_QUICK_STOP  = 3'h5;
localparam [2:0] ST_FAULT_REACT = 3'h6;
localparam [2:0] ST_FAULT       = 3'h7;

wire [5:0] pinSync;
wire       faultS;
wire       alarmS;
wire       mainsS;
wire       stopKeyS;
wire       reverseS;
wire       networkS;

reg  [2:0]         state_reg;
reg  [2:0]         state_next;
reg  [SPEED_W-1:0] lowSpeed_reg;
reg  [SPEED_W-1:0] highSpeed_reg;
reg  [SPEED_W-1:0] tolerance_reg;
reg                ioProfile_reg;
reg  [`DSW_EVENTS-1:0] irqStat_reg;
reg  [`DSW_EVENTS-1:0] irqMask_reg;
reg  [`DSW_EVENTS-1:0] irqStat_next;
reg  [15:0]        word_next;
reg  [15:0]        prevWord_reg;
reg  [SPEED_W-1:0] speedError;
wire               refReached;
wire               refOutside;
wire [`DSW_EVENTS-1:0] events;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisation
dsw_sync
#(
    .WIDTH (6)
)
u_pinSync
(
    .clock   (clock),
    .rst_n   (rst_n),
    .asyncIn ({networkCmd, reverseIn, stopKeyIn, mainsPresent, alarmIn,
               faultIn}),
    .syncOut (pinSync)
);

assign faultS   = pinSync[0];
assign alarmS   = pinSync[1];
assign mainsS   = pinSync[2];
assign stopKeyS = pinSync[3];
assign reverseS = pinSync[4];
assign networkS = pinSync[5];

////////////////////////////////////////////////////////////////////////////////
// Power state machine
always @*
begin
    state_next = state_reg;
    case (state_reg)
        ST_NOT_READY:
            state_next = ST_SO_DISABLED;
        ST_SO_DISABLED:
            if (cmdShutdown && mainsS)
                state_next = ST_READY;
        ST_READY:
            if (cmdDisableVoltage || cmdQuickStop)
                state_next = ST_SO_DISABLED;
            else if (cmdSwitchOn)
                state_next = ST_SWITCHED_ON;
        ST_SWITCHED_ON:
            if (cmdDisableVoltage || cmdQuickStop)
                state_next = ST_SO_DISABLED;
            else if (cmdShutdown)
                state_next = ST_READY;
            else if (cmdEnableOp && mainsS)
                state_next = ST_OP_ENABLED;
        ST_OP_ENABLED:
            if (cmdDisableVoltage)
                state_next = ST_SO_DISABLED;
            else if (cmdQuickStop)
                state_next = ST_QUICK_STOP;
            else if (cmdShutdown)
                state_next = ST_READY;
            else if (cmdDisableOp)
                state_next = ST_SWITCHED_ON;
        ST_QUICK_STOP:
            // Holds until the motor has come to rest or voltage is disabled
            if (cmdDisableVoltage || speedActual == {SPEED_W{1'b0}})
                state_next = ST_SO_DISABLED;
        ST_FAULT_REACT:
            state_next = ST_FAULT;
        ST_FAULT:
            // A reset request while the fault persists is ignored
            if (cmdFaultReset && !faultS)
                state_next = ST_SO_DISABLED;
        default:
            state_next = ST_NOT_READY;
    endcase
    // Fault overrides every state except the fault pair itself
    if (faultS && state_reg != ST_FAULT && state_reg != ST_FAULT_REACT)
        state_next = ST_FAULT_REACT;
end

////////////////////////////////////////////////////////////////////////////////
// Reference comparisons
always @*
begin
    if (speedActual >= speedRef)
        speedError = speedActual - speedRef;
    else
        speedError = speedRef - speedActual;
end

assign refReached = (speedError <= tolerance_reg);
assign refOutside = (speedRef < lowSpeed_reg) || (speedRef > highSpeed_reg);

////////////////////////////////////////////////////////////////////////////////
// Status word assembly; one value serves both profiles
// profile independent
always @*
begin
    word_next = `DSW_RST_WORD;
    case (state_next)
        ST_SO_DISABLED:
            word_next[`DSW_B_SODISABLED] = 1'b1;
        ST_READY:
        begin
            word_next[`DSW_B_READY] = 1'b1;
            word_next[`DSW_B_QSTOP] = 1'b1;
        end
        ST_SWITCHED_ON:
        begin
            // ready bit, the same in both profiles
            word_next[`DSW_B_READY]    = 1'b1;
            word_next[`DSW_B_SWITCHED] = 1'b1;
            word_next[`DSW_B_QSTOP]    = 1'b1;
        end
        ST_OP_ENABLED:
        begin
            word_next[`DSW_B_READY]     = 1'b1;
            word_next[`DSW_B_SWITCHED]  = 1'b1;
            word_next[`DSW_B_OPENABLED] = 1'b1;
            word_next[`DSW_B_QSTOP]     = 1'b1;
        end
        ST_QUICK_STOP:
        begin
            // quick stop reads low while active
            word_next[`DSW_B_READY]     = 1'b1;
            word_next[`DSW_B_SWITCHED]  = 1'b1;
            word_next[`DSW_B_OPENABLED] = 1'b1;
        end
        ST_FAULT_REACT:
        begin
            word_next[`DSW_B_READY]     = 1'b1;
            word_next[`DSW_B_SWITCHED]  = 1'b1;
            word_next[`DSW_B_OPENABLED] = 1'b1;
        end
        default:
            word_next[`DSW_B_READY] = 1'b0;
    endcase
    word_next[`DSW_B_FAULT]   = (state_next == ST_FAULT) ||
                                (state_next == ST_FAULT_REACT);
    word_next[`DSW_B_MAINS]   = mainsS;
    word_next[`DSW_B_ALARM]   = alarmS;
    // same bit in the simple profile
    word_next[`DSW_B_REMOTE]  = networkS;
    word_next[`DSW_B_REACHED] = refReached;
    word_next[`DSW_B_LIMIT]   = refOutside;
    // stop key, bits 12 and 13 stay zero
    word_next[`DSW_B_STOPKEY] = stopKeyS;
    word_next[`DSW_B_REVERSE] = reverseS;
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt events: rising edges of selected flags, any state change
assign events[`DSW_E_FAULT]   = word_next[`DSW_B_FAULT] &
                                ~prevWord_reg[`DSW_B_FAULT];
assign events[`DSW_E_ALARM]   = word_next[`DSW_B_ALARM] &
                                ~prevWord_reg[`DSW_B_ALARM];
assign events[`DSW_E_STOPKEY] = word_next[`DSW_B_STOPKEY] &
                                ~prevWord_reg[`DSW_B_STOPKEY];
assign events[`DSW_E_REACHED] = word_next[`DSW_B_REACHED] &
                                ~prevWord_reg[`DSW_B_REACHED];
assign events[`DSW_E_LIMIT]   = word_next[`DSW_B_LIMIT] &
                                ~prevWord_reg[`DSW_B_LIMIT];
assign events[`DSW_E_STATE]   = (state_next != state_reg);

always @*
begin
    irqStat_next = irqStat_reg;
    if (regWr && regAddr == `DSW_OFF_IRQ_STAT)
        irqStat_next = irqStat_reg & ~regWrData[`DSW_EVENTS-1:0];
    // A new event wins over a clear in the same cycle
    irqStat_next = irqStat_next | events;
end

////////////////////////////////////////////////////////////////////////////////
// State and status registers
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        state_reg       <= ST_NOT_READY;
        driveStateFlags <= `DSW_RST_WORD;
        prevWord_reg    <= `DSW_RST_WORD;
        irqStat_reg     <= {`DSW_EVENTS{1'b0}};
        irq             <= 1'b0;
    end
    else
    begin
        state_reg       <= state_next;
        // refreshed every cycle from live state
        driveStateFlags <= word_next;
        prevWord_reg    <= word_next;
        irqStat_reg     <= irqStat_next;
        irq             <= |(irqStat_next & irqMask_reg);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes; the status word and state code have no write path
// writes ignored
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        lowSpeed_reg  <= `DSW_RST_LOW_SPEED;
        highSpeed_reg <= `DSW_RST_HIGH_SPEED;
        tolerance_reg <= `DSW_RST_TOLERANCE;
        ioProfile_reg <= 1'b0;
        irqMask_reg   <= {`DSW_EVENTS{1'b0}};
    end
    else if (regWr)
    begin
        case (regAddr)
            `DSW_OFF_LOW_SPEED:
                lowSpeed_reg  <= regWrData[SPEED_W-1:0];
            `DSW_OFF_HIGH_SPEED:
                highSpeed_reg <= regWrData[SPEED_W-1:0];
            `DSW_OFF_TOLERANCE:
                tolerance_reg <= regWrData[SPEED_W-1:0];
            `DSW_OFF_PROFILE:
                ioProfile_reg <= regWrData[0];
            `DSW_OFF_IRQ_MASK:
                irqMask_reg   <= regWrData[`DSW_EVENTS-1:0];
            default:
                ioProfile_reg <= ioProfile_reg;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register reads: data valid the cycle after the strobe only
// Profile select only labels the word for readers; it never alters it
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
        regRdData <= 16'h0000;
    else if (regRd)
    begin
        case (regAddr)
            `DSW_OFF_FLAGS:
                regRdData <= driveStateFlags;
            `DSW_OFF_STATE:
                regRdData <= {13'h0000, state_reg};
            `DSW_OFF_LOW_SPEED:
                regRdData <= lowSpeed_reg;
            `DSW_OFF_HIGH_SPEED:
                regRdData <= highSpeed_reg;
            `DSW_OFF_TOLERANCE:
                regRdData <= tolerance_reg;
            `DSW_OFF_PROFILE:
                regRdData <= {15'h0000, ioProfile_reg};
            `DSW_OFF_IRQ_STAT:
                regRdData <= {10'h000, irqStat_reg};
            `DSW_OFF_IRQ_MASK:
                regRdData <= {10'h000, irqMask_reg};
            default:
                regRdData <= 16'h0000;
        endcase
    end
    else
        regRdData <= 16'h0000;
end

endmodule // dsw_drive_status_word

// [dsw_defines.vh]
// Constants of the drive status word block
`ifndef DSW_DEFINES_VH
`define DSW_DEFINES_VH

// Register offsets (word index on the plain port)
`define DSW_OFF_FLAGS      4'h0
`define DSW_OFF_STATE      4'h1
`define DSW_OFF_LOW_SPEED  4'h2
`define DSW_OFF_HIGH_SPEED 4'h3
`define DSW_OFF_TOLERANCE  4'h4
`define DSW_OFF_PROFILE    4'h5
`define DSW_OFF_IRQ_STAT   4'h6
`define DSW_OFF_IRQ_MASK   4'h7

// Status word bit positions
`define DSW_B_READY        0
`define DSW_B_SWITCHED     1
`define DSW_B_OPENABLED    2
`define DSW_B_FAULT        3
`define DSW_B_MAINS        4
`define DSW_B_QSTOP        5
`define DSW_B_SODISABLED   6
`define DSW_B_ALARM        7
`define DSW_B_REMOTE       9
`define DSW_B_REACHED      10
`define DSW_B_LIMIT        11
`define DSW_B_STOPKEY      14
`define DSW_B_REVERSE      15

// Interrupt event bit positions
`define DSW_E_FAULT        0
`define DSW_E_ALARM        1
`define DSW_E_STOPKEY      2
`define DSW_E_REACHED      3
`define DSW_E_LIMIT        4
`define DSW_E_STATE        5
`define DSW_EVENTS         6

// Reset values
`define DSW_RST_LOW_SPEED  16'h0000
`define DSW_RST_HIGH_SPEED 16'hffff
`define DSW_RST_TOLERANCE  16'h0000
`define DSW_RST_WORD       16'h0000

`endif

// [dsw_sync.v]
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
module dsw_sync
#(
    parameter WIDTH = 1
)
(
    // Clock and reset
    input  wire             clock,
    input  wire             rst_n,
    // Levels
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);

reg [WIDTH-1:0] stage1Reg;

always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        stage1Reg <= {WIDTH{1'b0}};
        syncOut   <= {WIDTH{1'b0}};
    end
    else
    begin
        stage1Reg <= asyncIn;
        syncOut   <= stage1Reg;
    end
end

endmodule // dsw_sync

// [dsw_drive_status_word_assertions.sv]
// Concurrent checks on the drive status word ports
`timescale 1ns/1ns
`include "dsw_defines.vh"
module dsw_status_checker
(
    // Clock and reset
    input wire        clock,
    input wire        rst_n,
    // Pins and commands
    input wire        faultIn,
    input wire        alarmIn,
    input wire        mainsPresent,
    input wire        stopKeyIn,
    input wire        reverseIn,
    input wire        networkCmd,
    input wire        cmdShutdown,
    input wire        cmdEnableOp,
    // Register port and word
    input wire [3:0]  regAddr,
    input wire        regRd,
    input wire [15:0] regRdData,
    input wire [15:0] driveStateFlags
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Synced pins start from zero, so pin checks wait after each reset
    logic [3:0] upCnt_reg;
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            upCnt_reg <= 4'h0;
        else if (upCnt_reg != 4'hf)
            upCnt_reg <= upCnt_reg + 4'h1;
    wire        up = (upCnt_reg == 4'hf);
    wire [15:0] w  = driveStateFlags;
    ////////////////////////////////////////////////////////////////////////
    sequence s_steady(x); ($stable(x) && up)[*5]; endsequence
    sequence s_sod;
        (w[6:0] == 7'h50 && mainsPresent)[*3] ##0 (cmdShutdown && !faultIn);
    endsequence
    sequence s_swon;
        (w[6:0] == 7'h33 && mainsPresent)[*3] ##0 (cmdEnableOp && !faultIn);
    endsequence
    property p_rsv; !w[8] && w[13:12] == 2'h0; endproperty
    property p_code;
        (w[6:0] & 7'h67) inside {7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07};
    endproperty
    property p_fault; (faultIn && up)[*5] |-> w[`DSW_B_FAULT]; endproperty
    property p_mains;
        s_steady(mainsPresent) |-> w[`DSW_B_MAINS] == mainsPresent;
    endproperty
    property p_alarm; s_steady(alarmIn) |-> w[`DSW_B_ALARM] == alarmIn;
    endproperty
    property p_net; s_steady(networkCmd) |-> w[`DSW_B_REMOTE] == networkCmd;
    endproperty
    property p_stopkey;
        s_steady(stopKeyIn) |-> w[`DSW_B_STOPKEY] == stopKeyIn;
    endproperty
    property p_reverse;
        s_steady(reverseIn) |-> w[`DSW_B_REVERSE] == reverseIn;
    endproperty
    property p_rdidle; !$past(regRd) |-> regRdData == 16'h0000; endproperty
    property p_rdword;
        $past(regRd) && $past(regAddr) == `DSW_OFF_FLAGS && $stable(w)
            |-> regRdData == w;
    endproperty
    property p_shut; s_sod |=> w[6:0] == 7'h31; endproperty
    property p_enable; s_swon |=> w[6:0] == 7'h37; endproperty
    ////////////////////////////////////////////////////////////////////////
    a_rsv: assert property (p_rsv)
        else $error("reserved status bits not zero");
    a_code: assert property (p_code)
        else $error("illegal power state pattern");
    a_fault: assert property (p_fault)
        else $error("fault pin not reported");
    a_mains: assert property (p_mains)
        else $error("mains flag wrong");
    a_alarm: assert property (p_alarm)
        else $error("alarm flag wrong");
    a_net: assert property (p_net)
        else $error("network source flag wrong");
    a_stopkey: assert property (p_stopkey)
        else $error("stop key flag wrong");
    a_reverse: assert property (p_reverse)
        else $error("direction flag wrong");
    a_rdidle: assert property (p_rdidle)
        else $error("read data outside read slot");
    a_rdword: assert property (p_rdword)
        else $error("status read differs from word");
    a_shut: assert property (p_shut)
        else $error("shutdown did not reach ready");
    a_enable: assert property (p_enable)
        else $error("enable did not reach running");
endmodule // dsw_status_checker

bind dsw_drive_status_word dsw_status_checker u_chk
(
    .clock(clock), .rst_n(rst_n), .faultIn(faultIn), .alarmIn(alarmIn),
    .mainsPresent(mainsPresent), .stopKeyIn(stopKeyIn),
    .reverseIn(reverseIn), .networkCmd(networkCmd),
    .cmdShutdown(cmdShutdown), .cmdEnableOp(cmdEnableOp),
    .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData),
    .driveStateFlags(driveStateFlags)
);

// [dsw_pin_model.sv]
// Power section and terminal model driving the drive status pins
`timescale 1ns/1ns
module dsw_pin_model
(
    // Clock
    input  wire        clock,
    // Requested levels: fault, alarm, mains, stop key, reverse, network
    input  wire  [5:0] pinReq,
    // Pins
    output logic       faultIn = 1'b0,
    output logic       alarmIn = 1'b0,
    output logic       mainsPresent = 1'b0,
    output logic       stopKeyIn = 1'b0,
    output logic       reverseIn = 1'b0,
    output logic       networkCmd = 1'b0
);
    // Pins are unrelated to the clock, so they move well off its edge
    always @(posedge clock)
    begin
        faultIn      <= #3 pinReq[0];
        mainsPresent <= #3 pinReq[2];
        alarmIn      <= #3 pinReq[1];
        stopKeyIn    <= #3 pinReq[3];
        reverseIn    <= #3 pinReq[4];
        networkCmd   <= #3 pinReq[5];
    end
endmodule // dsw_pin_model

// [tb_drive_status_word.sv]
// Self-checking bench for the drive status word block
`timescale 1ns/1ns
`include "dsw_defines.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_drive_status_word;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  pinReq = 6'h00;
    logic [6:0]  cmdVec = 7'h00;
    logic [15:0] speedRef = 16'h0000;
    logic [15:0] speedActual = 16'h0000;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    wire  [15:0] regRdData;
    wire  [15:0] driveStateFlags;
    wire         irq;
    wire         fltP, almP, mnsP, stpP, revP, netP;
    int          err_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          seed = 96;
    logic [31:0] rv, rv2;
    logic [15:0] rdVal, ref16, act16, exp16;
    logic [3:0]  rA [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'hf};
    // Speed inputs and tolerance start at zero, so reached reads one
    logic [15:0] rE [7] = '{16'h0440, 16'h0001, 16'h0000, 16'hffff,
                            16'h0000, 16'h0000, 16'h0000};
    int          wC [10] = '{0, 1, 2, 3, 2, 4, 0, 1, 2, 5};
    logic [6:0]  wF [10] = '{7'h31, 7'h33, 7'h37, 7'h33, 7'h37, 7'h50,
                             7'h31, 7'h33, 7'h37, 7'h17};
    logic [15:0] wS [10] = '{16'h2, 16'h3, 16'h4, 16'h3, 16'h4, 16'h1,
                             16'h2, 16'h3, 16'h4, 16'h5};
    ////////////////////////////////////////////////////////////////////////
    dsw_pin_model u_pins (.clock(clock), .pinReq(pinReq), .faultIn(fltP),
        .alarmIn(almP), .mainsPresent(mnsP), .stopKeyIn(stpP),
        .reverseIn(revP), .networkCmd(netP));
    dsw_drive_status_word dut (.clock(clock), .rst_n(rst_n),
        .faultIn(fltP), .alarmIn(almP), .mainsPresent(mnsP),
        .stopKeyIn(stpP), .reverseIn(revP), .networkCmd(netP),
        .cmdShutdown(cmdVec[0]), .cmdSwitchOn(cmdVec[1]),
        .cmdEnableOp(cmdVec[2]), .cmdDisableOp(cmdVec[3]),
        .cmdDisableVoltage(cmdVec[4]), .cmdQuickStop(cmdVec[5]),
        .cmdFaultReset(cmdVec[6]), .speedRef(speedRef),
        .speedActual(speedActual), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .driveStateFlags(driveStateFlags),
        .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            $display("[ERR] run length exp done got hung");
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clock);
        regWr     <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clock);
        regRd   <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic cmd(input int i);
        @(posedge clock);
        cmdVec[i] <= 1'b1;
        @(posedge clock);
        cmdVec    <= 7'h00;
        @(posedge clock);
        #1;
    endtask
    // Pins need two sync edges plus one update edge
    task automatic settle();
        repeat (6) @(posedge clock);
        #1;
    endtask
    function automatic logic [15:0] expFlags(logic [15:0] r, a, t, l, h,
                                             logic [3:0] p);
        logic [15:0] d;
        d = (a >= r) ? a - r : r - a;
        expFlags = 16'h0000;
        expFlags[`DSW_B_ALARM]   = p[0];
        expFlags[`DSW_B_STOPKEY] = p[1];
        expFlags[`DSW_B_REVERSE] = p[2];
        expFlags[`DSW_B_REMOTE]  = p[3];
        expFlags[`DSW_B_REACHED] = (d <= t);
        expFlags[`DSW_B_LIMIT]   = (r < l) || (r > h);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rd(rA[i], rdVal);
            `CHK("reset value", rE[i], rdVal);
        end
        wr(4'h0, 16'hffff);
        wr(4'h1, 16'h0007);
        rd(4'h0, rdVal);
        `CHK("written word", 16'h0440, rdVal);
        @(posedge clock);
        pinReq[2]   <= 1'b1;
        speedActual <= 16'h0064;
        settle();
        `CHK("mains flag", 7'h50, driveStateFlags[6:0]);
        for (int i = 0; i < 10; i++)
        begin
            cmd(wC[i]);
            `CHK("state flags", wF[i], driveStateFlags[6:0]);
            rd(4'h1, rdVal);
            `CHK("state code", wS[i], rdVal);
        end
        @(posedge clock);
        speedActual <= 16'h0000;
        settle();
        `CHK("stopped", 7'h50, driveStateFlags[6:0]);
        `CHK("reached", 1'b1, driveStateFlags[`DSW_B_REACHED]);
        wr(4'h6, 16'h003f);
        wr(4'h7, 16'h0001);
        pinReq[0] <= 1'b1;
        settle();
        `CHK("fault flag", 1'b1, driveStateFlags[`DSW_B_FAULT]);
        `CHK("irq on fault", 1'b1, irq);
        cmd(6);
        rd(4'h1, rdVal);
        `CHK("fault held", 16'h0007, rdVal);
        rd(4'h6, rdVal);
        `CHK("fault event", 1'b1, rdVal[`DSW_E_FAULT]);
        wr(4'h6, 16'h0001);
        #1 `CHK("irq cleared", 1'b0, irq);
        pinReq[1:0] <= 2'b10;
        settle();
        `CHK("irq masked", 1'b0, irq);
        cmd(6);
        rd(4'h1, rdVal);
        `CHK("fault reset", 16'h0001, rdVal);
        `CHK("fault gone", 1'b0, driveStateFlags[`DSW_B_FAULT]);
        rd(4'h6, rdVal);
        `CHK("alarm event", 1'b1, rdVal[`DSW_E_ALARM]);
        wr(4'h7, 16'h0002);
        // New mask reaches irq one edge after the write is taken
        @(posedge clock);
        #1 `CHK("irq unmasked", 1'b1, irq);
        for (int n = 0; n < 40; n++)
        begin
            rv  = $random(seed);
            rv2 = $random(seed);
            ref16 = {8'h00, rv[7:0]};
            act16 = ref16 + {14'h0000, rv[9:8]};
            wr(4'h2, {8'h00, rv[19:12]});
            wr(4'h3, {8'h00, rv[27:20]});
            wr(4'h4, {14'h0000, rv[11:10]});
            wr(4'h5, {15'h0000, rv[28]});
            @(posedge clock);
            pinReq      <= {rv2[3:1], 1'b1, rv2[0], 1'b0};
            speedRef    <= ref16;
            speedActual <= act16;
            settle();
            exp16 = expFlags(ref16, act16, {14'h0000, rv[11:10]},
                {8'h00, rv[19:12]}, {8'h00, rv[27:20]}, rv2[3:0]);
            `CHK("flag bits", exp16, driveStateFlags & 16'hce80);
            `CHK("state bits", 7'h50, driveStateFlags[6:0]);
        end
        end_of_test();
    end
endmodule // tb_drive_status_word
